// *** src/cla_defines.svh ***
// Offsets, field positions, reset values and sizes for the layer address control bank
`ifndef CLA_DEFINES_SVH
`define CLA_DEFINES_SVH

`define CLA_NUM_LAYERS       32
`define CLA_OFF_WRITE_BASE   12'h0310
`define CLA_OFF_WRITE_TOFF   12'h0390
`define CLA_OFF_WRITE_MOFF   12'h0410
`define CLA_OFF_WRITE_CHOFF  12'h0490
`define CLA_OFF_READ_BASE    12'h0510
`define CLA_OFF_CTRL0        12'h0590
`define CLA_OFF_MASK_RANGE   12'h0610
`define CLA_OFF_TAP_PTR      12'h0690
`define CLA_BANK_SPAN        12'h0080
`define CLA_ADDR_MSB         16
`define CLA_CTRL0_MSB        16
`define CLA_TAP_MAX_MSB      10
`define CLA_TAP_SAD_LSB      16
`define CLA_TAP_SAD_MSB      26
`define CLA_RESET_VALUE      32'h0000_0000
`define CLA_READ_LIMIT       17'h0_2000

`endif

// *** src/cla_pkg.sv ***
// Types for the layer address control bank
package cla_pkg;

	typedef struct packed {
		logic        wide_output;
		logic [3:0]  sum_feed;
		logic        global_bus_source;
		logic        column_pad_only;
		logic        relu_enable;
		logic        max_pool;
		logic        pool_enable;
		logic        parallel_mode;
		logic        independent_sum;
		logic        share_proc0;
		logic [3:0]  group_share;
	} cla_ctrl_t;

	typedef struct packed {
		logic [16:0] write_base;
		logic [16:0] write_toff;
		logic [16:0] write_moff;
		logic [16:0] write_choff;
		logic [16:0] read_base;
		cla_ctrl_t   ctrl;
		logic [15:0] mask_start;
		logic [15:0] mask_max;
		logic [10:0] tap_start;
		logic [10:0] tap_max;
	} cla_layer_t;

	typedef struct packed {
		logic        valid;
		logic [4:0]  layer;
		logic        timeslot_mode_enable;
		logic [3:0]  timeslot_count;
		logic [3:0]  timeslot_index;
		logic [15:0] mask_enable;
		logic [15:0] mask_counter;
		logic        multipass_on;
		logic [8:0]  expansion_max;
	} cla_wreq_t;

	typedef enum logic [1:0] {
		CLA_TAP_IDLE,
		CLA_TAP_RUN
	} cla_tap_state_t;

endpackage

// *** src/cla_layer_bank.sv ***
// Per-layer address and control register bank with write address and pointer generation
`include "cla_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module cla_layer_bank
	import cla_pkg::*;
(
	input  wire logic        clk,             // 100 MHz clock
	input  wire logic        rst_b,           // Asynchronous reset, active low
	input  wire logic        hsel,            // AHB slave select
	input  wire logic [31:0] haddr,           // AHB address
	input  wire logic [1:0]  htrans,          // AHB transfer type
	input  wire logic        hwrite,          // AHB write
	input  wire logic [2:0]  hsize,           // AHB size
	input  wire logic [31:0] hwdata,          // AHB write data
	input  wire logic        hready,          // AHB ready in
	output logic      [31:0] hrdata,          // AHB read data
	output logic             hreadyout,       // AHB ready out
	output logic             hresp,           // AHB response, always OKAY
	input  wire logic [4:0]  active_layer,    // Layer in processing
	input  wire cla_wreq_t   wreq,            // Result write request
	output logic      [16:0] write_addr,      // Effective result write address
	output logic             write_addr_vld,  // Write address valid
	output logic      [16:0] read_base_out,   // Read base of active layer
	output logic             read_base_err,   // Read base beyond per-processor memory
	output cla_ctrl_t        ctrl_out,        // Control flags of active layer
	input  wire logic        mask_stride_start, // Restart mask counter at stride
	input  wire logic        mask_channel_step, // One output channel done
	output logic      [15:0] mask_addr,       // Mask memory address counter
	output logic             mask_at_max,     // Mask counter at maximum
	input  wire logic        tap_init,        // Initial processing of layer
	input  wire logic        tap_step,        // Advance tap pointer
	output logic      [10:0] tap_addr,        // Tap buffer memory pointer
	output logic             tap_rollover     // Tap pointer rolled over, pulse
);

	cla_layer_t     layer_q [0:`CLA_NUM_LAYERS-1];
	logic           wr_pend_q;
	logic [3:0]     wr_reg_q;
	logic [4:0]     wr_layer_q;
	cla_tap_state_t tap_state_q;
	cla_layer_t     cur;
	logic [11:0]    a_off;
	logic [3:0]     a_reg;
	logic           a_hit;
	logic [4:0]     a_lay;

	function automatic logic [3:0] reg_index(input logic [11:0] off);
		logic [11:0] rel;
		rel = off - `CLA_OFF_WRITE_BASE;
		if (off < `CLA_OFF_WRITE_BASE || off >= `CLA_OFF_TAP_PTR + `CLA_BANK_SPAN || off[1:0] != 2'b00)
			reg_index = 4'hF;
		else
			reg_index = {1'b0, rel[9:7]};
	endfunction

	// Layer number counts from the bank base, not from offset zero
	function automatic logic [4:0] layer_index(input logic [11:0] off);
		logic [11:0] rel;
		rel = off - `CLA_OFF_WRITE_BASE;
		layer_index = rel[6:2];
	endfunction

	function automatic logic [31:0] reg_read(input cla_layer_t l, input logic [3:0] idx);
		case (idx)
			4'h0:    reg_read = {15'h0000, l.write_base};
			4'h1:    reg_read = {15'h0000, l.write_toff};
			4'h2:    reg_read = {15'h0000, l.write_moff};
			4'h3:    reg_read = {15'h0000, l.write_choff};
			4'h4:    reg_read = {15'h0000, l.read_base};
			4'h5:    reg_read = {15'h0000, l.ctrl};
			4'h6:    reg_read = {l.mask_start, l.mask_max};
			4'h7:    reg_read = {5'h00, l.tap_start, 5'h00, l.tap_max};
			default: reg_read = `CLA_RESET_VALUE;
		endcase
	endfunction

	// Address phase decode: offset from bank base gives register in bits 9:7, layer in bits 6:2
	assign a_off = haddr[11:0];
	assign a_reg = reg_index(a_off);
	assign a_lay = layer_index(a_off);
	assign a_hit = hsel && hready && htrans[1] && (haddr[31:12] == 20'h0_0000);

	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			wr_pend_q  <= 1'b0;
			wr_reg_q   <= 4'h0;
			wr_layer_q <= 5'h00;
		end
		else
		begin
			wr_pend_q  <= a_hit && hwrite && (a_reg != 4'hF);
			wr_reg_q   <= a_reg;
			wr_layer_q <= a_lay;
		end
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			hrdata <= `CLA_RESET_VALUE;
		else if (a_hit && !hwrite)
			hrdata <= (a_reg == 4'hF) ? `CLA_RESET_VALUE : reg_read(layer_q[a_lay], a_reg);
	end

	// Data phase write; only defined fields are stored
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			for (int i = 0; i < `CLA_NUM_LAYERS; i++)
				layer_q[i] <= '0;
		end
		else if (wr_pend_q)
		begin
			case (wr_reg_q)
				4'h0:    layer_q[wr_layer_q].write_base  <= hwdata[`CLA_ADDR_MSB:0];
				4'h1:    layer_q[wr_layer_q].write_toff  <= hwdata[`CLA_ADDR_MSB:0];
				4'h2:    layer_q[wr_layer_q].write_moff  <= hwdata[`CLA_ADDR_MSB:0];
				4'h3:    layer_q[wr_layer_q].write_choff <= hwdata[`CLA_ADDR_MSB:0];
				4'h4:    layer_q[wr_layer_q].read_base   <= hwdata[`CLA_ADDR_MSB:0];
				4'h5:    layer_q[wr_layer_q].ctrl        <= cla_ctrl_t'(hwdata[`CLA_CTRL0_MSB:0]);
				4'h6:
				begin
					layer_q[wr_layer_q].mask_start <= hwdata[31:16];
					layer_q[wr_layer_q].mask_max   <= hwdata[15:0];
				end
				4'h7:
				begin
					layer_q[wr_layer_q].tap_start <= hwdata[`CLA_TAP_SAD_MSB:`CLA_TAP_SAD_LSB];
					layer_q[wr_layer_q].tap_max   <= hwdata[`CLA_TAP_MAX_MSB:0];
				end
				default: ;
			endcase
		end
	end

	assign cur = layer_q[active_layer];

	// Control flags fan out to datapath
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			ctrl_out      <= '0;
			read_base_out <= 17'h0_0000;
			read_base_err <= 1'b0;
		end
		else
		begin
			ctrl_out      <= cur.ctrl;
			read_base_out <= cur.read_base;
			read_base_err <= cur.read_base >= `CLA_READ_LIMIT;
		end
	end

	// Write address composition
	cla_layer_t  wl;
	logic [16:0] ts_term;
	logic [16:0] mk_term;
	logic [16:0] mp_term;
	logic [15:0] mp_quot;
	assign wl = layer_q[wreq.layer];

	always_comb
	begin
		ts_term = 17'h0_0000;
		mk_term = 17'h0_0000;
		mp_term = 17'h0_0000;
		mp_quot = 16'h0000;
		if (wreq.timeslot_mode_enable && wreq.timeslot_count != 4'h0)
			ts_term = 17'(wl.write_toff * wreq.timeslot_index);
		if (wreq.mask_enable != 16'h0000 && wl.mask_max > wl.mask_start)
			mk_term = 17'(wl.write_moff * wreq.mask_counter);
		if (wreq.multipass_on && wreq.expansion_max != 9'h000)
		begin
			mp_quot = 16'((wreq.mask_counter + 16'(wreq.expansion_max) - 16'h0001) / wreq.expansion_max);
			mp_term = 17'(wl.write_choff * mp_quot);
		end
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			write_addr     <= 17'h0_0000;
			write_addr_vld <= 1'b0;
		end
		else
		begin
			write_addr     <= wl.write_base + ts_term + mk_term + mp_term;
			write_addr_vld <= wreq.valid;
		end
	end

	// Mask memory address counter
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			mask_addr <= 16'h0000;
		else if (mask_stride_start)
			mask_addr <= cur.mask_start;
		else if (mask_channel_step && mask_addr < cur.mask_max)
			mask_addr <= mask_addr + 16'h0001;
	end

	// At or beyond maximum: a start above maximum must also stop the counter
	assign mask_at_max = (mask_addr >= cur.mask_max);

	// Tap buffer pointer
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			tap_state_q  <= CLA_TAP_IDLE;
			tap_addr     <= 11'h000;
			tap_rollover <= 1'b0;
		end
		else
		begin
			tap_rollover <= 1'b0;
			case (tap_state_q)
				CLA_TAP_IDLE:
				begin
					if (tap_init)
					begin
						tap_addr    <= cur.tap_start;
						tap_state_q <= CLA_TAP_RUN;
					end
				end
				CLA_TAP_RUN:
				begin
					if (tap_init)
						tap_addr <= cur.tap_start;
					else if (tap_step && tap_addr == cur.tap_max)
					begin
						tap_addr     <= cur.tap_start;
						tap_rollover <= 1'b1;
					end
					else if (tap_step)
						tap_addr <= tap_addr + 11'h001;
				end
				default: tap_state_q <= CLA_TAP_IDLE;
			endcase
		end
	end

endmodule

`default_nettype wire

// *** verification/cla_layer_bank_props.sv ***
// Assertions on the layer address control bank ports
`timescale 1ns/1ps
`default_nettype none
module cla_layer_bank_props
	import cla_pkg::*;
(
	input wire logic        clk,               // Clock
	input wire logic        rst_b,             // Reset
	input wire logic        hreadyout,         // Bus ready
	input wire logic        hresp,             // Bus response
	input wire cla_wreq_t   wreq,              // Write request
	input wire logic        write_addr_vld,    // Address valid
	input wire logic        mask_stride_start, // Mask restart
	input wire logic        mask_channel_step, // Mask step
	input wire logic [15:0] mask_addr,         // Mask counter
	input wire logic        mask_at_max,       // Mask at max
	input wire logic        tap_init,          // Tap load
	input wire logic        tap_step,          // Tap step
	input wire logic [10:0] tap_addr,          // Tap pointer
	input wire logic        tap_rollover       // Tap wrap pulse
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	logic tap_armed_q;
	// Steps before the first load are ignored by the pointer
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			tap_armed_q <= 1'b0;
		else if (tap_init)
			tap_armed_q <= 1'b1;
	end
	sequence s_mstep;
		mask_channel_step && !mask_stride_start;
	endsequence
	sequence s_tstep;
		tap_step && !tap_init;
	endsequence
	property p_bus; hreadyout && !hresp; endproperty
	property p_vld; wreq.valid |=> write_addr_vld; endproperty
	property p_novld; !wreq.valid |=> !write_addr_vld; endproperty
	property p_minc; s_mstep ##0 !mask_at_max |=> mask_addr == $past(mask_addr) + 16'h0001; endproperty
	property p_mhold; s_mstep ##0 mask_at_max |=> $stable(mask_addr); endproperty
	property p_midle; !mask_stride_start && !mask_channel_step |=> $stable(mask_addr); endproperty
	property p_tinc; s_tstep ##0 tap_armed_q ##1 !tap_rollover |-> tap_addr == $past(tap_addr) + 11'h001; endproperty
	property p_troll; tap_rollover |-> $past(tap_step); endproperty
	property p_tidle; !tap_init && !tap_step |=> $stable(tap_addr); endproperty
	a_bus: assert property (p_bus) else $error("bus not ready or not okay");
	a_vld: assert property (p_vld) else $error("write address valid missing");
	a_novld: assert property (p_novld) else $error("write address valid spurious");
	a_minc: assert property (p_minc) else $error("mask counter did not step");
	a_mhold: assert property (p_mhold) else $error("mask counter passed maximum");
	a_midle: assert property (p_midle) else $error("mask counter moved idle");
	a_tinc: assert property (p_tinc) else $error("tap pointer did not step");
	a_troll: assert property (p_troll) else $error("tap wrap without step");
	a_tidle: assert property (p_tidle) else $error("tap pointer moved idle");
endmodule
`default_nettype wire

// *** verification/cla_layer_bank_bench.sv ***
// Self-checking bench for the layer address control bank
`include "cla_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module cla_layer_bank_bench
	import cla_pkg::*;
;
	logic clk = 0, rst_b = 0, hsel = 0, hwrite = 0, hreadyout, hresp;
	logic mask_stride_start = 0, mask_channel_step = 0, tap_init = 0, tap_step = 0;
	logic write_addr_vld, read_base_err, mask_at_max, tap_rollover;
	logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
	logic [1:0]  htrans = '0;
	logic [2:0]  hsize = 3'h2;
	logic [4:0]  active_layer = '0;
	logic [16:0] write_addr, read_base_out;
	logic [15:0] mask_addr;
	logic [10:0] tap_addr;
	cla_wreq_t   wreq = '0;
	cla_ctrl_t   ctrl_out;
	int          failures = 0, checked = 0, cycles = 0;
	logic [31:0] fmask_bad [3] = '{32'h0000_0300, 32'h0000_0710, 32'h0001_0310};
	always #5 clk = ~clk;
	cla_layer_bank dut_u (.clk, .rst_b, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata,
		.hreadyout, .hresp, .active_layer, .wreq, .write_addr, .write_addr_vld, .read_base_out, .read_base_err,
		.ctrl_out, .mask_stride_start, .mask_channel_step, .mask_addr, .mask_at_max, .tap_init, .tap_step,
		.tap_addr, .tap_rollover);
	task automatic print_verdict;
		if (failures == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			failures++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= wr;
		haddr <= a;
		do @(posedge clk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	task automatic chk(input logic [31:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0000_0000);
		cmp(rd, exp);
	endtask
	function automatic logic [31:0] ra(input int i, input int ly);
		return 32'(`CLA_OFF_WRITE_BASE) + 32'(i) * 32'(`CLA_BANK_SPAN) + 32'(ly) * 32'h0000_0004;
	endfunction
	function automatic logic [31:0] fmask(input int i);
		return i < 6 ? 32'h0001_FFFF : (i == 6 ? 32'hFFFF_FFFF : 32'h07FF_07FF);
	endfunction
	task automatic wcase(input logic ts, input logic [3:0] cnt, input logic [15:0] men, input logic mp,
		input logic [8:0] xm, input logic [16:0] e);
		@(posedge clk);
		wreq <= '{1'b1, 5'd3, ts, cnt, 4'd3, men, 16'd5, mp, xm};
		@(posedge clk);
		#1 cmp(32'(write_addr), 32'(e));
	endtask
	// Pulse one of stride start, channel step, tap init, tap step
	task automatic pulse(input int s);
		@(posedge clk);
		{mask_stride_start, mask_channel_step, tap_init, tap_step} <= 4'b1000 >> s;
		@(posedge clk);
		{mask_stride_start, mask_channel_step, tap_init, tap_step} <= 4'h0;
		#1;
	endtask
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 8000)
		begin
			failures++;
			print_verdict();
		end
	end
	initial
	begin
		repeat (12) @(posedge clk);
		rst_b <= 1'b1;
		for (int i = 0; i < 8; i++)
		begin
			chk(ra(i, 31), 32'h0000_0000);
			bus(1'b1, ra(i, 5), 32'hFFFF_FFFF);
			chk(ra(i, 5), fmask(i));
			chk(ra(i, 4), 32'h0000_0000);
			chk(ra(i, 6), 32'h0000_0000);
		end
		foreach (fmask_bad[k])
		begin
			bus(1'b1, fmask_bad[k], 32'hFFFF_FFFF);
			chk(fmask_bad[k], 32'h0000_0000);
		end
		chk(ra(0, 0), 32'h0000_0000);
		bus(1'b1, ra(0, 3), 32'h0000_0100);
		bus(1'b1, ra(1, 3), 32'h0000_0010);
		bus(1'b1, ra(2, 3), 32'h0000_0020);
		bus(1'b1, ra(3, 3), 32'h0000_0400);
		bus(1'b1, ra(6, 3), 32'h0001_0010);
		wcase(1'b0, 4'd0, 16'h0, 1'b0, 9'd0, 17'h0_0100);
		wcase(1'b1, 4'd4, 16'h0, 1'b0, 9'd0, 17'h0_0130);
		wcase(1'b1, 4'd0, 16'h0, 1'b0, 9'd0, 17'h0_0100);
		wcase(1'b0, 4'd0, 16'h1, 1'b0, 9'd0, 17'h0_01A0);
		wcase(1'b0, 4'd0, 16'h0, 1'b1, 9'd4, 17'h0_0900);
		wcase(1'b1, 4'd4, 16'h1, 1'b1, 9'd4, 17'h0_09D0);
		@(posedge clk);
		wreq <= '0;
		active_layer <= 5'd2;
		for (int i = 0; i < 17; i++)
		begin
			bus(1'b1, ra(5, 2), 32'h0000_0001 << i);
			repeat (2) @(posedge clk);
			#1 cmp(32'(ctrl_out), 32'h0000_0001 << i);
		end
		for (int v = 'h1FFF; v <= 'h2000; v++)
		begin
			bus(1'b1, ra(4, 2), 32'(v));
			repeat (2) @(posedge clk);
			#1 cmp(32'({read_base_err, read_base_out}), 32'(v) | (v >= 'h2000 ? 32'h0002_0000 : 32'h0));
		end
		bus(1'b1, ra(6, 2), 32'h0010_0012);
		for (int k = 0; k < 5; k++)
		begin
			pulse(k % 4 == 0 ? 0 : 1);
			cmp(32'(mask_addr), 32'h10 + (k == 4 ? 0 : (k > 2 ? 2 : k)));
			cmp(32'(mask_at_max), 32'(k == 2 || k == 3));
		end
		bus(1'b1, ra(7, 2), 32'h0005_0007);
		for (int k = 0; k < 4; k++)
		begin
			pulse(k == 0 ? 2 : 3);
			cmp(32'({tap_rollover, tap_addr}), k == 3 ? 32'h805 : 32'h5 + 32'(k));
		end
		print_verdict();
	end
endmodule
bind cla_layer_bank cla_layer_bank_props chk_u (.clk, .rst_b, .hreadyout, .hresp, .wreq, .write_addr_vld,
	.mask_stride_start, .mask_channel_step, .mask_addr, .mask_at_max, .tap_init, .tap_step, .tap_addr,
	.tap_rollover);
`default_nettype wire
